//--- logic/afd_alu_addr.sv
// ALU flag generation and data operand addressing behind an AXI4-Lite slave.
// Functional notes
// - Flags as destination: flag ops update flags, drop result; others write result to flags.
// - Clearing flags register sets only zero.
// - Negative flag copies result bit seven.
// - Overflow flag marks signed sign-bit change.
// - Zero flag marks all-zero result.
// - Nibble carry from low four bits.
// - Carry out of result MSB.
// - Subtract adds complement; carries mean no-borrow.
// - Rotates load carry from shifted-out bit.
// - Flags bits seven to five read zero.
// - Inherent, literal, direct, indirect, optional indexed.
// - Jump carries 20-bit target.
// - Direct operand address is instruction low byte.
// - Access bit one joins bank select.
// - Access bit zero uses access bank.
// - Full 12-bit address ignores bank select.
// - Destination bit picks file or accumulator.
// - No destination field: implied destination used.
// - Pointer pairs are directly writable registers.
// - Post-increment, post-decrement and pre-increment indirect operands adjust pointer automatically.
// - Pointer pair holds 12-bit address.
// - Post-decrement uses pointer, then decrements.
// - Pointer steps carry across pair, no flags.
`timescale 1ns/1ns
module afd_alu_addr
   import afd_pkg::*;
(
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire afd_axi_req_t axi_i,
   output afd_axi_rsp_t axi_o,
   output afd_mem_wr_t mem_o,
   output afd_prog_t prog_o
);
   // ************************************************************
   // State and helpers
   // ************************************************************
   afd_state_t st; // All registered state.
   afd_state_t next_st; // Value for the next edge.
   afd_instr_t ins; // Instruction word being executed.
   logic exec; // Instruction register written this cycle.
   logic [1:0] ptr_idx; // Selected pointer pair.
   logic [DADDR_W-1:0] ptr_cur; // Pointer before the access.
   logic [DADDR_W-1:0] ptr_new; // Pointer after the access.
   logic [DADDR_W-1:0] eaddr; // Resolved data address.
   logic dest_file; // Result goes to a file, not the accumulator.
   logic [7:0] op_a; // First operand.
   logic [7:0] b_eff; // Accumulator, complemented for subtract.
   logic [8:0] sum9; // Adder with carry out.
   logic [4:0] nib5; // Low nibble adder.
   logic [7:0] alu_res; // Result byte.
   afd_flags_t alu_flags; // Flag outcome before masking.
   afd_flags_t flag_mask; // Flags that this operation touches.
   afd_flags_t flags_new; // Flags after the operation.
   logic [32:0] rv; // Hit bit and word of a register read.
   logic [DATA_W-1:0] wv; // Word after byte strobes.
   logic rd_flags_take; // Read of the flags register accepted.

   // Register read: bit 32 says the offset is mapped.
   function automatic logic [32:0] read_word(input afd_state_t s, input logic [7:0] a);
      logic [32:0] r;
      r = {1'b1, 32'h0000_0000};
      case (a)
         OFF_FLAGS: r[FLAGS_W-1:0] = s.flags;
         OFF_ACCUM: r[7:0] = s.accum;
         OFF_BANK: r[BANK_W-1:0] = s.bank;
         OFF_FILEOP: r[7:0] = s.file_op;
         OFF_LONG: r[PADDR_W-1:0] = s.long_op;
         OFF_INSTR: r[32] = 1'b1;
         OFF_RESULT: r[8:0] = {s.last_dest_file, s.last_res};
         OFF_EADDR: r[DADDR_W-1:0] = s.last_addr;
         OFF_CFG: r[0] = s.cfg_ext;
         default: r[32] = 1'b0;
      endcase
      // The pointer pairs sit in a row of words, one per pair.
      for (int k = 0; k < PTR_N; k++)
      begin
         if (a == 8'(OFF_PTR0 + PTR_STRIDE * k))
         begin
            r = {1'b1, 20'h00000, s.ptr[k]};
         end
      end
      return r;
   endfunction

   // ************************************************************
   // Next-state logic
   // ************************************************************
   // Everything is worked out from the held write, so that one
   // instruction changes flags, pointer and destination together.
   always_comb
   begin
      next_st = st;
      ins = afd_instr_t'(st.w_data);
      exec = st.aw_held && st.w_held && !st.rsp.bvalid && (st.aw_addr == OFF_INSTR);
      // Codes above the last pair fold onto it rather than alias a hole.
      ptr_idx = (ins.ptr > PTR_LAST) ? PTR_LAST : ins.ptr;
      ptr_cur = st.ptr[ptr_idx];
      ptr_new = ptr_cur;
      eaddr = 12'h000;
      dest_file = 1'b0;
      op_a = st.file_op;
      b_eff = st.accum;
      alu_res = 8'h00;
      alu_flags = st.flags;
      flag_mask = '0;
      rv = 33'h0_0000_0000;
      wv = 32'h0000_0000;
      rd_flags_take = st.rsp.arready && axi_i.arvalid && (axi_i.araddr == OFF_FLAGS);
      next_st.mem.we = 1'b0;
      next_st.prog.load = 1'b0;

      // Operand source and data address per addressing mode.
      unique case (ins.mode)
         MODE_INHERENT:
         begin
            op_a = st.accum;
         end
         MODE_LITERAL:
         begin
            op_a = ins.addr;
         end
         MODE_DIRECT:
         begin
            dest_file = ins.dest;
            // Indexed offset from the third pair only with the extended set.
            if (st.cfg_ext && !ins.acc && (ins.addr < ACCESS_SPLIT))
            begin
               eaddr = st.ptr[PTR_INDEXED] + {4'h0, ins.addr};
            end
            else if (ins.acc)
            begin
               eaddr = {st.bank, ins.addr};
            end
            else if (ins.addr >= ACCESS_SPLIT)
            begin
               eaddr = {ACCESS_HI_BANK, ins.addr};
            end
            else
            begin
               eaddr = {ACCESS_LO_BANK, ins.addr};
            end
         end
         MODE_FULL:
         begin
            dest_file = ins.dest;
            eaddr = st.long_op[DADDR_W-1:0];
         end
         MODE_INDIRECT:
         begin
            dest_file = ins.dest;
            // Pointer steps wrap over the whole 12-bit pair.
            unique case (ins.ind)
               IND_PLAIN: eaddr = ptr_cur;
               IND_POST_INCREMENT_OPERAND:
               begin
                  eaddr = ptr_cur;
                  ptr_new = ptr_cur + PTR_STEP;
               end
               IND_POST_DECREMENT_OPERAND:
               begin
                  eaddr = ptr_cur;
                  ptr_new = ptr_cur - PTR_STEP;
               end
               IND_PREINC:
               begin
                  ptr_new = ptr_cur + PTR_STEP;
                  eaddr = ptr_new;
               end
               IND_ACCUMULATOR_OFFSET_OPERAND: eaddr = ptr_cur + {{4{st.accum[7]}}, st.accum};
               default: eaddr = ptr_cur;
            endcase
         end
         default: op_a = st.accum;
      endcase

      // Subtract adds the complement plus one.
      if (ins.op == OP_SUB)
      begin
         b_eff = ~st.accum;
      end
      sum9 = {1'b0, op_a} + {1'b0, b_eff} + {8'h00, ins.op == OP_SUB};
      nib5 = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, ins.op == OP_SUB};

      // Result and the set of flags each operation touches.
      unique case (ins.op)
         OP_ADD, OP_SUB:
         begin
            alu_res = sum9[7:0];
            flag_mask = FLAGS_ALL;
            alu_flags.carry = sum9[8];
            alu_flags.nib = nib5[4];
            alu_flags.ovf = (op_a[7] == b_eff[7]) && (sum9[7] != op_a[7]);
         end
         OP_AND:
         begin
            alu_res = op_a & st.accum;
            flag_mask = FLAGS_ZN;
         end
         OP_IOR:
         begin
            alu_res = op_a | st.accum;
            flag_mask = FLAGS_ZN;
         end
         OP_XOR:
         begin
            alu_res = op_a ^ st.accum;
            flag_mask = FLAGS_ZN;
         end
         OP_MOVF:
         begin
            alu_res = op_a;
            flag_mask = FLAGS_ZN;
         end
         OP_CLEAR:
         begin
            alu_res = 8'h00;
            flag_mask = FLAGS_Z;
         end
         OP_SWAP: alu_res = {op_a[3:0], op_a[7:4]};
         OP_RLC:
         begin
            alu_res = {op_a[6:0], st.flags.carry};
            alu_flags.carry = op_a[7];
            flag_mask = FLAGS_CZN;
         end
         OP_RRC:
         begin
            alu_res = {st.flags.carry, op_a[7:1]};
            alu_flags.carry = op_a[0];
            flag_mask = FLAGS_CZN;
         end
         OP_MOVW: alu_res = st.accum;
         OP_JUMP: alu_res = op_a;
         default: alu_res = op_a;
      endcase
      alu_flags.neg = alu_res[7];
      alu_flags.zero = (alu_res == 8'h00);
      flags_new = afd_flags_t'((alu_flags & flag_mask) | (st.flags & ~flag_mask));

      // Write channel: address and data are taken in either order.
      if (st.rsp.awready && axi_i.awvalid)
      begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = axi_i.awaddr;
      end
      if (st.rsp.wready && axi_i.wvalid)
      begin
         next_st.w_held = 1'b1;
         next_st.w_data = axi_i.wdata;
         next_st.w_strb = axi_i.wstrb;
      end
      if (st.rsp.bvalid && axi_i.bready)
      begin
         next_st.rsp.bvalid = 1'b0;
      end

      // Both halves held: perform the register write.
      if (st.aw_held && st.w_held && !st.rsp.bvalid)
      begin
         rv = read_word(st, st.aw_addr);
         wv = rv[31:0];
         for (int i = 0; i < STRB_W; i++)
         begin
            if (st.w_strb[i])
            begin
               wv[8*i +: 8] = st.w_data[8*i +: 8];
            end
         end
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.rsp.bvalid = 1'b1;
         next_st.rsp.bresp = rv[32] ? RESP_OKAY : RESP_SLVERR;
         case (st.aw_addr)
            OFF_FLAGS: next_st.flags = afd_flags_t'(wv[FLAGS_W-1:0]);
            OFF_ACCUM: next_st.accum = wv[7:0];
            OFF_BANK: next_st.bank = wv[BANK_W-1:0];
            OFF_FILEOP: next_st.file_op = wv[7:0];
            OFF_LONG: next_st.long_op = wv[PADDR_W-1:0];
            OFF_CFG: next_st.cfg_ext = wv[0];
            default: next_st.cfg_ext = st.cfg_ext;
         endcase
         for (int k = 0; k < PTR_N; k++)
         begin
            if (st.aw_addr == 8'(OFF_PTR0 + PTR_STRIDE * k))
            begin
               next_st.ptr[k] = wv[DADDR_W-1:0];
            end
         end
      end

      // Execute: all effects land on the same edge as the response.
      if (exec)
      begin
         next_st.last_res = alu_res;
         next_st.last_addr = eaddr;
         next_st.last_dest_file = dest_file;
         next_st.ptr[ptr_idx] = ptr_new;
         if (ins.op == OP_JUMP)
         begin
            next_st.prog.load = 1'b1;
            next_st.prog.target = st.long_op;
         end
         if (dest_file && (eaddr == FLAGS_FILE_ADDR))
         begin
            // A flag-touching result is dropped; others land as data.
            if (flag_mask != '0)
            begin
               next_st.flags = flags_new;
            end
            else
            begin
               next_st.flags = afd_flags_t'(alu_res[FLAGS_W-1:0]);
            end
         end
         else
         begin
            next_st.flags = flags_new;
            if (dest_file)
            begin
               next_st.mem.we = 1'b1;
               next_st.mem.addr = eaddr;
               next_st.mem.wdata = alu_res;
            end
            else if (ins.op != OP_JUMP)
            begin
               next_st.accum = alu_res;
            end
         end
      end
      next_st.rsp.awready = !next_st.aw_held && !next_st.rsp.bvalid;
      next_st.rsp.wready = !next_st.w_held && !next_st.rsp.bvalid;

      // Read channel: one read at a time, answered the next cycle.
      if (st.rsp.rvalid && axi_i.rready)
      begin
         next_st.rsp.rvalid = 1'b0;
      end
      if (st.rsp.arready && axi_i.arvalid)
      begin
         rv = read_word(st, axi_i.araddr);
         next_st.rsp.rvalid = 1'b1;
         next_st.rsp.rdata = rv[31:0];
         next_st.rsp.rresp = rv[32] ? RESP_OKAY : RESP_SLVERR;
      end
      next_st.rsp.arready = !next_st.rsp.rvalid;
   end

   // ************************************************************
   // State register
   // ************************************************************
   // Flags reset to zero; their power-up value is otherwise unknown.
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         st <= ST_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign axi_o = st.rsp;
   assign mem_o = st.mem;
   assign prog_o = st.prog;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);

   a_flags_dest_kept: assert property (exec && dest_file && (eaddr == FLAGS_FILE_ADDR)
      && (flag_mask != '0) |=> !st.mem.we && (st.flags == $past(flags_new)))
      else $error("Flags destination wrote a result.");
   a_clear_sets_zero: assert property (exec && (ins.op == OP_CLEAR)
      |=> st.flags.zero && (st.flags.carry == $past(st.flags.carry)))
      else $error("Clear did not leave only zero set.");
   a_neg_from_msb: assert property (exec && flag_mask.neg
      |=> st.flags.neg == $past(alu_res[7]))
      else $error("Negative flag differs from result MSB.");
   a_zero_from_res: assert property (exec && flag_mask.zero
      |=> st.flags.zero == ($past(alu_res) == 8'h00))
      else $error("Zero flag differs from result.");
   a_sub_no_borrow: assert property (exec && (ins.op == OP_SUB)
      |=> st.flags.carry == ($past(op_a) >= $past(st.accum)))
      else $error("Subtract carry is not the inverted borrow.");
   a_flags_upper_zero: assert property (rd_flags_take
      |=> st.rsp.rvalid && (st.rsp.rdata[DATA_W-1:FLAGS_W] == '0))
      else $error("Flags upper bits read nonzero.");
   a_bank_direct: assert property (exec && (ins.mode == MODE_DIRECT) && ins.acc
      |=> st.last_addr == {$past(st.bank), $past(ins.addr)})
      else $error("Banked direct address wrong.");
   a_post_decrement_operand_ptr: assert property (exec && (ins.mode == MODE_INDIRECT)
      && (ins.ind == IND_POST_DECREMENT_OPERAND) |=> (st.last_addr == $past(ptr_cur))
      && (st.ptr[$past(ptr_idx)] == $past(ptr_cur) - PTR_STEP))
      else $error("Post-decrement pointer wrong.");
endmodule

//--- logic/afd_pkg.sv
// Shared types and constants for the ALU flag and data addressing block.
package afd_pkg;
   // ************************************************************
   // Widths
   // ************************************************************
   localparam int AXI_AW = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int FLAGS_W = 5;
   localparam int BANK_W = 4;
   localparam int DADDR_W = 12; // Linear data address.
   localparam int PADDR_W = 20; // Program address of a jump.
   localparam int PTR_N = 3;
   // ************************************************************
   // Register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] OFF_FLAGS = 8'h00;
   localparam logic [7:0] OFF_ACCUM = 8'h04;
   localparam logic [7:0] OFF_BANK = 8'h08;
   localparam logic [7:0] OFF_PTR0 = 8'h0C;
   localparam logic [7:0] PTR_STRIDE = 8'h04;
   localparam logic [7:0] OFF_FILEOP = 8'h18;
   localparam logic [7:0] OFF_LONG = 8'h1C;
   localparam logic [7:0] OFF_INSTR = 8'h20;
   localparam logic [7:0] OFF_RESULT = 8'h24;
   localparam logic [7:0] OFF_EADDR = 8'h28;
   localparam logic [7:0] OFF_CFG = 8'h2C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ************************************************************
   // Data address map
   // ************************************************************
   localparam logic [11:0] FLAGS_FILE_ADDR = 12'hFF0; // Flags register as a file.
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
   localparam logic [1:0] PTR_INDEXED = 2'h2;
   localparam logic [1:0] PTR_LAST = 2'h2;
   localparam logic [11:0] PTR_STEP = 12'h001;
   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [3:0] {OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_MOVF,
      OP_CLEAR, OP_SWAP, OP_RLC, OP_RRC, OP_MOVW, OP_JUMP} afd_op_t;
   typedef enum logic [2:0] {MODE_INHERENT, MODE_LITERAL, MODE_DIRECT, MODE_FULL,
      MODE_INDIRECT} afd_mode_t;
   typedef enum logic [2:0] {IND_PLAIN, IND_POST_INCREMENT_OPERAND, IND_POST_DECREMENT_OPERAND, IND_PREINC,
      IND_ACCUMULATOR_OFFSET_OPERAND} afd_ind_t;
   typedef struct packed {
      logic [9:0] spare;
      logic [1:0] ptr;
      afd_ind_t ind;
      afd_mode_t mode;
      afd_op_t op;
      logic dest;
      logic acc;
      logic [7:0] addr;
   } afd_instr_t;
   typedef struct packed {
      logic neg;
      logic ovf;
      logic zero;
      logic nib;
      logic carry;
   } afd_flags_t;
   localparam afd_flags_t FLAGS_ALL = 5'h1F;
   localparam afd_flags_t FLAGS_ZN = 5'h14;
   localparam afd_flags_t FLAGS_Z = 5'h04;
   localparam afd_flags_t FLAGS_CZN = 5'h15;
   typedef struct packed {
      logic awvalid;
      logic [AXI_AW-1:0] awaddr;
      logic wvalid;
      logic [DATA_W-1:0] wdata;
      logic [STRB_W-1:0] wstrb;
      logic bready;
      logic arvalid;
      logic [AXI_AW-1:0] araddr;
      logic rready;
   } afd_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } afd_axi_rsp_t;
   typedef struct packed {
      logic we;
      logic [DADDR_W-1:0] addr;
      logic [7:0] wdata;
   } afd_mem_wr_t;
   typedef struct packed {
      logic load;
      logic [PADDR_W-1:0] target;
   } afd_prog_t;
   typedef struct packed {
      afd_axi_rsp_t rsp;
      logic aw_held;
      logic [AXI_AW-1:0] aw_addr;
      logic w_held;
      logic [DATA_W-1:0] w_data;
      logic [STRB_W-1:0] w_strb;
      afd_flags_t flags;
      logic [7:0] accum;
      logic [BANK_W-1:0] bank;
      logic [PTR_N-1:0][DADDR_W-1:0] ptr;
      logic [7:0] file_op;
      logic [PADDR_W-1:0] long_op;
      logic cfg_ext;
      logic [7:0] last_res;
      logic last_dest_file;
      logic [DADDR_W-1:0] last_addr;
      afd_mem_wr_t mem;
      afd_prog_t prog;
   } afd_state_t;
   localparam afd_state_t ST_RESET = '0;
endpackage

//--- testbench/alu_flags_and_data_addressing_tb.sv
// Self-checking testbench for the ALU flag and data addressing block.
`timescale 1ns/1ns
module alu_flags_and_data_addressing_tb
   import afd_pkg::*;
;
   // ********
   // Signals and stimulus tables
   // ********
   logic clock_i; // Core clock, 50 ns period.
   logic resetn_i; // Active low reset.
   afd_axi_req_t req; // Bus requests driven by the bench.
   afd_axi_rsp_t rsp;
   afd_mem_wr_t mem;
   afd_prog_t prog;
   afd_mem_wr_t seen_mem; // Memory pulse caught at the response edge.
   afd_prog_t seen_prog; // Jump pulse caught at the response edge.
   int bad_count;
   int compares;
   // Operand pairs: the first three add, the rest subtract.
   localparam logic [7:0] TA [6] = '{8'h7F, 8'hFF, 8'h08, 8'h05, 8'h00, 8'h80};
   localparam logic [7:0] TW [6] = '{8'h01, 8'h01, 8'h08, 8'h05, 8'h01, 8'h01};
   // Direct cases: extended set bit, access bit, low byte, resolved address.
   localparam logic [5:0] DX = 6'h30;
   localparam logic [5:0] DA = 6'h04;
   localparam logic [7:0] DF [6] = '{8'h70, 8'h20, 8'h20, 8'h00, 8'h10, 8'h70};
   localparam logic [11:0] DE [6] = '{12'hF70, 12'h020, 12'h520, 12'hABC, 12'h110, 12'hF70};
   // Indirect cases: kind, pair, start value, address used, value after.
   localparam afd_ind_t IK [5] = '{IND_POST_INCREMENT_OPERAND, IND_POST_DECREMENT_OPERAND, IND_ACCUMULATOR_OFFSET_OPERAND, IND_PLAIN, IND_PREINC};
   localparam logic [7:0] IP [5] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h01};
   localparam logic [11:0] II [5] = '{12'h0FF, 12'h100, 12'h200, 12'h345, 12'h1FF};
   localparam logic [11:0] IE [5] = '{12'h0FF, 12'h100, 12'h1FE, 12'h345, 12'h200};
   localparam logic [11:0] IQ [5] = '{12'h100, 12'h0FF, 12'h200, 12'h345, 12'h200};

   afd_alu_addr u_afd_alu_addr (.clock_i(clock_i), .resetn_i(resetn_i), .axi_i(req),
      .axi_o(rsp), .mem_o(mem), .prog_o(prog));

   // Free running clock.
   initial
   begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   // ********
   // Checking and bus tasks
   // ********
   // Prints the counts and the verdict, then stops the run.
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Compares one data word; case inequality lets no unknown pass.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %08h expected %08h", $time, got, exp);
      end
   endtask

   // Compares one bus response code.
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      chk({30'h0, got}, {30'h0, exp});
   endtask

   // A wait that never ends is a mismatch and closes the run.
   task automatic timed_out();
      chk(32'h0, 32'h1);
      finish_test();
   endtask

   // Write cycle: address and data offered together, each released when taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clock_i);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clock_i);
         if (req.awvalid && rsp.awready)
            req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready)
            req.wvalid <= 1'b0;
         if (rsp.bvalid)
         begin
            r = rsp.bresp;
            seen_mem = mem;
            seen_prog = prog;
            req.bready <= 1'b0;
            break;
         end
      end
      if (n == 50)
         timed_out();
   endtask

   // Read cycle: rready stays high until the data is sampled.
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clock_i);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clock_i);
         if (req.arvalid && rsp.arready)
            req.arvalid <= 1'b0;
         if (rsp.rvalid)
         begin
            d = rsp.rdata;
            r = rsp.rresp;
            req.rready <= 1'b0;
            break;
         end
      end
      if (n == 50)
         timed_out();
   endtask

   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk_resp(r, RESP_OKAY);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d, exp);
      chk_resp(r, RESP_OKAY);
   endtask

   // Executes one instruction by writing the instruction register.
   task automatic ex(input afd_op_t op, input afd_mode_t m, input logic [7:0] a,
      input logic acc, input logic dest, input afd_ind_t ind, input logic [1:0] p);
      afd_instr_t i;
      i = '0;
      i.op = op;
      i.mode = m;
      i.addr = a;
      i.acc = acc;
      i.dest = dest;
      i.ind = ind;
      i.ptr = p;
      wr_ok(OFF_INSTR, i);
   endtask

   // Reference add: {result, neg, ovf, zero, nib, carry}; subtract adds the complement.
   function automatic logic [12:0] arith(input logic sub, input logic [7:0] a,
      input logic [7:0] w);
      logic [7:0] b;
      logic [8:0] s;
      logic [4:0] h;
      b = sub ? ~w : w;
      s = {1'b0, a} + {1'b0, b} + {8'h00, sub};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, sub};
      return {s[7:0], s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
   endfunction

   // ********
   // Scenarios
   // ********
   // Reset values, unimplemented bits, pointer width and an unmapped offset.
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      rd_chk(OFF_FLAGS, 32'h0);
      wr_ok(OFF_FLAGS, 32'hFFFF_FFFF);
      rd_chk(OFF_FLAGS, 32'h0000_001F);
      wr_ok(OFF_PTR0, 32'h0000_FFFF);
      rd_chk(OFF_PTR0, 32'h0000_0FFF);
      wr(8'h40, 32'h1, r);
      chk_resp(r, RESP_SLVERR);
      rd(8'h40, d, r);
      chk(d, 32'h0);
      chk_resp(r, RESP_SLVERR);
   endtask

   // Add and subtract against the reference, boundary operands included.
   task automatic t_arith();
      logic [12:0] e;
      for (int i = 0; i < 6; i++)
      begin
         e = arith(i > 2, TA[i], TW[i]);
         wr_ok(OFF_ACCUM, {24'h0, TW[i]});
         ex(i > 2 ? OP_SUB : OP_ADD, MODE_LITERAL, TA[i], 1'b0, 1'b0, IND_PLAIN, 2'h0);
         rd_chk(OFF_ACCUM, {24'h0, e[12:5]});
         rd_chk(OFF_FLAGS, {27'h0, e[4:0]});
      end
   endtask

   // Rotates through carry, to the accumulator and to a banked file.
   task automatic t_rotate();
      wr_ok(OFF_FLAGS, 32'h08);
      wr_ok(OFF_FILEOP, 32'h80);
      ex(OP_RLC, MODE_DIRECT, 8'h20, 1'b0, 1'b0, IND_PLAIN, 2'h0);
      rd_chk(OFF_ACCUM, 32'h00);
      rd_chk(OFF_FLAGS, 32'h0D);
      chk({31'h0, seen_mem.we}, 32'h0);
      wr_ok(OFF_FLAGS, 32'h01);
      wr_ok(OFF_BANK, 32'h5);
      wr_ok(OFF_FILEOP, 32'h01);
      ex(OP_RRC, MODE_DIRECT, 8'h34, 1'b1, 1'b1, IND_PLAIN, 2'h0);
      chk({19'h0, seen_mem.we, seen_mem.addr}, 32'h1534);
      chk({24'h0, seen_mem.wdata}, 32'h80);
      rd_chk(OFF_RESULT, 32'h180);
      rd_chk(OFF_FLAGS, 32'h11);
   endtask

   // Direct, access bank, banked, full address and indexed literal offset.
   task automatic t_direct();
      wr_ok(OFF_PTR0 + 8'h08, 32'h100);
      wr_ok(OFF_LONG, 32'hABC);
      wr_ok(OFF_FILEOP, 32'h5A);
      for (int i = 0; i < 6; i++)
      begin
         wr_ok(OFF_CFG, {31'h0, DX[i]});
         ex(OP_MOVF, i == 3 ? MODE_FULL : MODE_DIRECT, DF[i], DA[i], 1'b1, IND_PLAIN, 2'h0);
         chk({11'h0, seen_mem}, {12'h1, DE[i], 8'h5A});
         rd_chk(OFF_EADDR, {20'h0, DE[i]});
      end
      wr_ok(OFF_CFG, 32'h0);
   endtask

   // Pointer operands: the kinds of post adjustment, carry and borrow across the pair, flags kept.
   task automatic t_indirect();
      wr_ok(OFF_FLAGS, 32'h1F);
      wr_ok(OFF_ACCUM, 32'hFE);
      wr_ok(OFF_FILEOP, 32'h12);
      for (int i = 0; i < 5; i++)
      begin
         wr_ok(OFF_PTR0 + 8'(IP[i] * PTR_STRIDE), {20'h0, II[i]});
         ex(OP_SWAP, MODE_INDIRECT, 8'h00, 1'b0, 1'b1, IK[i], IP[i][1:0]);
         chk({11'h0, seen_mem}, {12'h1, IE[i], 8'h21});
         rd_chk(OFF_PTR0 + 8'(IP[i] * PTR_STRIDE), {20'h0, IQ[i]});
      end
      rd_chk(OFF_FLAGS, 32'h1F);
   endtask

   // Flags register named as destination of flag and non-flag operations.
   task automatic t_flags_dest();
      wr_ok(OFF_FLAGS, 32'h1B);
      ex(OP_CLEAR, MODE_DIRECT, 8'hF0, 1'b0, 1'b1, IND_PLAIN, 2'h0);
      chk({31'h0, seen_mem.we}, 32'h0);
      rd_chk(OFF_FLAGS, 32'h1F);
      wr_ok(OFF_ACCUM, 32'h80);
      wr_ok(OFF_FILEOP, 32'h80);
      ex(OP_ADD, MODE_DIRECT, 8'hF0, 1'b0, 1'b1, IND_PLAIN, 2'h0);
      rd_chk(OFF_FLAGS, 32'h0D);
      wr_ok(OFF_FILEOP, 32'h3A);
      ex(OP_SWAP, MODE_DIRECT, 8'hF0, 1'b0, 1'b1, IND_PLAIN, 2'h0);
      rd_chk(OFF_FLAGS, 32'h03);
      rd_chk(OFF_ACCUM, 32'h80);
   endtask

   // Jump carries a 20-bit target and leaves the accumulator alone.
   task automatic t_jump();
      wr_ok(OFF_LONG, 32'h000A_BCDE);
      ex(OP_JUMP, MODE_LITERAL, 8'h00, 1'b0, 1'b0, IND_PLAIN, 2'h0);
      chk({11'h0, seen_prog.load, seen_prog.target}, 32'h001A_BCDE);
      rd_chk(OFF_ACCUM, 32'h80);
      ex(OP_XOR, MODE_INHERENT, 8'h00, 1'b0, 1'b0, IND_PLAIN, 2'h0);
      rd_chk(OFF_FLAGS, 32'h07);
   endtask

   // ********
   // Main sequence
   // ********
   initial
   begin
      req = '0;
      seen_mem = '0;
      seen_prog = '0;
      bad_count = 0;
      compares = 0;
      resetn_i = 1'b0;
      repeat (5) @(posedge clock_i);
      resetn_i <= 1'b1;
      t_regs();
      t_arith();
      t_rotate();
      t_direct();
      t_indirect();
      t_flags_dest();
      t_jump();
      finish_test();
   end
endmodule
